// File: rtl/timer2_updown_clkout_baud.sv
/*
 * Third timer/counter: up/down auto-reload, 50% clock-out on the timer
 * pin, and baud-rate generation for the serial port.
 * Assumes all inputs synchronous to ref_clk (the oscillator clock) and
 * a register master that strobes for one cycle at a time.
 */
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module timer2_updown_clkout_baud
  import timer2_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // timer clock pin, three-signal form
  input wire logic timer_clock_io_pin_in,
  output logic timer_clock_io_pin_out,
  output logic timer_clock_io_pin_oe_n,
  // trigger / direction pin
  input wire logic timer_trigger_dir_pin,
  // serial port
  input wire logic first_timer_ovf_tick,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  // interrupt request level
  output logic timer_irq
);

  // ****************************************
  // state
  // ****************************************
  timer_control_t ctrl_reg;
  timer_mode_t mode_reg;
  logic [15:0] cnt_reg;
  logic [15:0] rld_reg;
  logic [2:0] mc_reg;
  logic ck_samp_reg;
  logic ck_prev_reg;
  logic trig_samp_reg;
  logic trig_prev_reg;
  logic [7:0] rdata_reg;
  logic pin_out_reg;
  logic pin_oe_n_reg;
  logic irq_reg;
  logic [1:0] baud_tick_reg;

  // ****************************************
  // decode
  // ****************************************
  wire ctrl_wr = reg_wr && (reg_addr == CTRL_ADDR);
  wire mode_wr = reg_wr && (reg_addr == MODE_ADDR);
  wire rld_lo_wr = reg_wr && (reg_addr == RLD_LO_ADDR);
  wire rld_hi_wr = reg_wr && (reg_addr == RLD_HI_ADDR);
  wire cnt_lo_wr = reg_wr && (reg_addr == CNT_LO_ADDR);
  wire cnt_hi_wr = reg_wr && (reg_addr == CNT_HI_ADDR);
  wire cnt_wr = cnt_lo_wr || cnt_hi_wr;
  timer_control_t ctrl_w;
  assign ctrl_w = timer_control_t'(reg_wdata);

  // ****************************************
  // modes
  // ****************************************
  wire baud_mode = ctrl_reg.tx_baud_source_select || ctrl_reg.rx_baud_source_select;
  wire clkout_mode = mode_reg.clock_out_enable && !ctrl_reg.timer_counter_select;
  wire updown_mode = mode_reg.down_count_enable && !baud_mode && !clkout_mode;
  // up by default; direction pin steers only in up/down mode
  wire up_dir = !updown_mode || timer_trigger_dir_pin;

  // ****************************************
  // count pulses
  // ****************************************
  wire mc_tick = (mc_reg == MC_LAST);
  // pin sampled once per machine cycle, so the fastest edge is fosc/12
  wire ext_fall = mc_tick && ck_prev_reg && !ck_samp_reg;
  wire fast_clk = baud_mode || clkout_mode;
  wire int_tick = fast_clk ? 1'b1 : mc_tick;
  wire tick = ctrl_reg.timer_run && (ctrl_reg.timer_counter_select ? ext_fall : int_tick);

  // ****************************************
  // count and wrap
  // ****************************************
  wire at_wrap = up_dir ? (cnt_reg == COUNT_TOP) : (cnt_reg == rld_reg);
  wire wrap = tick && at_wrap;
  wire [15:0] wrap_val = up_dir ? rld_reg : COUNT_TOP;
  wire [15:0] step_val = up_dir ? 16'(cnt_reg + 16'h0001) : 16'(cnt_reg - 16'h0001);
  wire [15:0] run_val = !tick ? cnt_reg : (at_wrap ? wrap_val : step_val);

  // trigger edge: high sample, low sample, acted on at the next machine cycle
  wire trig_event = mc_tick && trig_prev_reg && !trig_samp_reg;
  wire trig_used = trig_event && ctrl_reg.external_trigger_enable && !updown_mode;
  // plain auto-reload reloads on a trigger; baud mode only flags it
  wire trig_reload = trig_used && !baud_mode && !clkout_mode;
  wire [15:0] hw_val = trig_reload ? rld_reg : run_val;
  wire [15:0] cnt_next = {cnt_hi_wr ? reg_wdata : hw_val[15:8], cnt_lo_wr ? reg_wdata : hw_val[7:0]};

  // ****************************************
  // flags: hardware set wins over a software clear
  // ****************************************
  wire tf_set = wrap && !baud_mode && !clkout_mode;
  wire exf_toggle = wrap && updown_mode;
  wire tf_base = ctrl_wr ? ctrl_w.timer_overflow_flag : ctrl_reg.timer_overflow_flag;
  wire exf_base = ctrl_wr ? ctrl_w.timer_external_flag : ctrl_reg.timer_external_flag;
  wire tf_next = tf_base || tf_set;
  wire exf_next = (exf_base ^ exf_toggle) || trig_used;
  timer_control_t ctrl_next;
  always_comb begin
    ctrl_next = ctrl_wr ? ctrl_w : ctrl_reg;
    ctrl_next.timer_overflow_flag = tf_next;
    ctrl_next.timer_external_flag = exf_next;
  end
  wire [7:0] mode_next = mode_wr ? {6'h00, reg_wdata[1:0]} : mode_reg;
  wire [15:0] rld_next = {rld_hi_wr ? reg_wdata : rld_reg[15:8], rld_lo_wr ? reg_wdata : rld_reg[7:0]};

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] rd_mux =
    (reg_addr == CTRL_ADDR) ? ctrl_reg :
    (reg_addr == MODE_ADDR) ? mode_reg :
    (reg_addr == RLD_LO_ADDR) ? rld_reg[7:0] :
    (reg_addr == RLD_HI_ADDR) ? rld_reg[15:8] :
    (reg_addr == CNT_LO_ADDR) ? cnt_reg[7:0] :
    (reg_addr == CNT_HI_ADDR) ? cnt_reg[15:8] : 8'h00;

  // ****************************************
  // register updates
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= timer_control_t'(CTRL_RESET);
      mode_reg <= timer_mode_t'(MODE_RESET);
      cnt_reg <= COUNT_RESET;
      rld_reg <= RELOAD_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= timer_mode_t'(mode_next);
      cnt_reg <= cnt_next;
      rld_reg <= rld_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_reg <= 3'h0;
      ck_samp_reg <= 1'b0;
      ck_prev_reg <= 1'b0;
      trig_samp_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      mc_reg <= mc_tick ? 3'h0 : 3'(mc_reg + 3'h1);
      if (mc_tick) begin
        ck_samp_reg <= timer_clock_io_pin_in;
        ck_prev_reg <= ck_samp_reg;
        trig_samp_reg <= timer_trigger_dir_pin;
        trig_prev_reg <= trig_samp_reg;
      end
    end
  end

  // ****************************************
  // pin and interrupt outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      pin_out_reg <= 1'b1;
      pin_oe_n_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
      // toggling at each overflow of a full-rate count gives fosc/(2*(65536-reload))
      if (clkout_mode && wrap) begin
        pin_out_reg <= !pin_out_reg;
      end
      pin_oe_n_reg <= !clkout_mode;
      irq_reg <= tf_next || exf_next;
    end
  end

  // ****************************************
  // serial port baud pulses, tx = 0, rx = 1
  // ****************************************
  wire t2_baud_ovf = wrap && baud_mode;
  wire [1:0] src_sel = {ctrl_reg.rx_baud_source_select, ctrl_reg.tx_baud_source_select};
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_baud
      logic [3:0] div_reg;
      logic tick_reg;
      wire src = src_sel[ch] ? t2_baud_ovf : first_timer_ovf_tick;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          div_reg <= 4'h0;
          tick_reg <= 1'b0;
        end else begin
          if (src) begin
            div_reg <= 4'(div_reg + 4'h1);
          end
          tick_reg <= src && (div_reg == BAUD_DIV_LAST);
        end
      end
      // one flip-flop per channel keeps each output bit single-driven
      assign baud_tick_reg[ch] = tick_reg;
    end
  endgenerate

  assign reg_rdata = rdata_reg;
  assign timer_clock_io_pin_out = pin_out_reg;
  assign timer_clock_io_pin_oe_n = pin_oe_n_reg;
  assign tx_baud_tick = baud_tick_reg[0];
  assign rx_baud_tick = baud_tick_reg[1];
  assign timer_irq = irq_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_UP_STEP: assert property (
    tick && updown_mode && timer_trigger_dir_pin && !at_wrap && !cnt_wr && !trig_reload
    |=> cnt_reg == 16'($past(cnt_reg) + 16'h0001))
    else $error("up count did not step by one");
  AST_UP_RELOAD: assert property (
    wrap && up_dir && !cnt_wr && !baud_mode && !clkout_mode
    |=> (cnt_reg == $past(rld_reg)) && ctrl_reg.timer_overflow_flag)
    else $error("overflow did not reload or flag");
  AST_DOWN_STEP: assert property (
    tick && !up_dir && !at_wrap && !cnt_wr
    |=> cnt_reg == 16'($past(cnt_reg) - 16'h0001))
    else $error("down count did not step by one");
  AST_DOWN_UNDERFLOW: assert property (
    wrap && !up_dir && !cnt_wr
    |=> (cnt_reg == COUNT_TOP) && ctrl_reg.timer_overflow_flag)
    else $error("underflow did not load all ones");
  AST_EXF_TOGGLE: assert property (
    wrap && updown_mode && !ctrl_wr
    |=> ctrl_reg.timer_external_flag != $past(ctrl_reg.timer_external_flag))
    else $error("external flag did not toggle on wrap");
  AST_CLKOUT_PIN: assert property (
    wrap && clkout_mode |=> timer_clock_io_pin_out != $past(timer_clock_io_pin_out))
    else $error("clock-out pin did not toggle");
  AST_NO_FLAG_QUIET: assert property (
    wrap && (baud_mode || clkout_mode) && !ctrl_reg.timer_overflow_flag && !ctrl_wr
    |=> !ctrl_reg.timer_overflow_flag)
    else $error("overflow flag set in baud or clock-out mode");
  AST_BAUD_RELOAD: assert property (
    wrap && baud_mode && !cnt_wr |=> cnt_reg == $past(rld_reg))
    else $error("baud rollover did not reload");
  AST_TRIG_NO_RELOAD: assert property (
    trig_used && baud_mode && !wrap && !cnt_wr && !ctrl_wr
    |=> ctrl_reg.timer_external_flag && (cnt_reg != $past(rld_reg) || $past(run_val) == $past(rld_reg)))
    else $error("baud trigger reloaded or failed to flag");
  AST_TRIG_EDGE: assert property (
    mc_tick && timer_trigger_dir_pin ##1 (!mc_tick)[*5] ##1 mc_tick && !timer_trigger_dir_pin
    ##1 (!mc_tick)[*5] ##1 mc_tick && ctrl_reg.external_trigger_enable && !updown_mode && !ctrl_wr
    |=> ctrl_reg.timer_external_flag)
    else $error("trigger edge not flagged in third machine cycle");
  AST_PIN_RELEASED: assert property (
    !mode_reg.clock_out_enable || ctrl_reg.timer_counter_select |=> timer_clock_io_pin_oe_n)
    else $error("pin driven outside clock-out mode");
  AST_RESET_DIR: assert property (
    $rose(rst_n) |-> !mode_reg.down_count_enable)
    else $error("down-count enable not clear after reset");

  // checks written from the register fields and from the mode wires (clkout_mode, baud_mode, updown_mode)
  AST_CLKOUT_OE: assert property (
    mode_reg.clock_out_enable && !ctrl_reg.timer_counter_select |=> !timer_clock_io_pin_oe_n)
    else $error("clock-out mode did not drive the pin");
  AST_CLKOUT_IRQ: assert property (
    clkout_mode && wrap && !trig_used && !ctrl_wr && !ctrl_reg.timer_overflow_flag && !ctrl_reg.timer_external_flag
    |=> !timer_irq)
    else $error("clock-out rollover raised the interrupt");
  AST_STOPPED_HOLDS: assert property (
    !ctrl_reg.timer_run && !cnt_wr && !trig_reload |=> $stable(cnt_reg))
    else $error("count moved with the run bit clear");
  AST_FAST_COUNT: assert property (
    ctrl_reg.timer_run && baud_mode && !ctrl_reg.timer_counter_select && !cnt_wr && cnt_reg != COUNT_TOP
    |=> cnt_reg == 16'($past(cnt_reg) + 16'h0001))
    else $error("baud timer did not step every clock");
  AST_COUNTER_EDGE: assert property (
    ctrl_reg.timer_counter_select && !(mc_tick && ck_prev_reg && !ck_samp_reg) && !cnt_wr && !trig_reload
    |=> $stable(cnt_reg))
    else $error("counter moved without a pin falling edge");
  AST_BAUD_SELECT: assert property (
    wrap && !ctrl_reg.tx_baud_source_select && !ctrl_reg.rx_baud_source_select && !clkout_mode
    |=> ctrl_reg.timer_overflow_flag)
    else $error("wrap outside baud mode did not flag");
  AST_UPDOWN_NO_TRIG: assert property (
    updown_mode && !wrap && !ctrl_wr && !ctrl_reg.timer_external_flag
    |=> !ctrl_reg.timer_external_flag)
    else $error("direction pin raised the external flag");
  // a baud pulse must trace back to the stream its select picks
  AST_TX_SOURCE: assert property (
    tx_baud_tick |-> ($past(ctrl_reg.tx_baud_source_select) ? $past(wrap) : $past(first_timer_ovf_tick)))
    else $error("transmit pulse from the wrong source");
  AST_RX_SOURCE: assert property (
    rx_baud_tick |-> ($past(ctrl_reg.rx_baud_source_select) ? $past(wrap) : $past(first_timer_ovf_tick)))
    else $error("receive pulse from the wrong source");
  // sixteen source events per pulse, so never two pulses within eight clocks
  AST_TX_TICK_SPACING: assert property (
    tx_baud_tick |=> (!tx_baud_tick) [*8])
    else $error("transmit pulses closer than the divider allows");
  AST_RX_TICK_SPACING: assert property (
    rx_baud_tick |=> (!rx_baud_tick) [*8])
    else $error("receive pulses closer than the divider allows");

  COV_UP_OVERFLOW: cover property (wrap && up_dir && !baud_mode && !clkout_mode);
  COV_DOWN_UNDERFLOW: cover property (wrap && !up_dir);
  COV_TX_BAUD: cover property (tx_baud_tick && ctrl_reg.tx_baud_source_select);
  COV_CLKOUT_EDGE: cover property (clkout_mode && $rose(timer_clock_io_pin_out));
  COV_TRIG_FLAG: cover property (trig_used && baud_mode);

endmodule : timer2_updown_clkout_baud

// File: rtl/timer2_pkg.sv
/*
 * Shared constants and register layouts for the up/down, clock-out and
 * baud-rate timer. Assumes an 8-bit register port and one oscillator clock.
 */
package timer2_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'hC8;
  localparam logic [7:0] MODE_ADDR = 8'hC9;
  localparam logic [7:0] RLD_LO_ADDR = 8'hCA;
  localparam logic [7:0] RLD_HI_ADDR = 8'hCB;
  localparam logic [7:0] CNT_LO_ADDR = 8'hCC;
  localparam logic [7:0] CNT_HI_ADDR = 8'hCD;

  // ****************************************
  // field layouts
  // ****************************************
  typedef struct packed {
    logic timer_overflow_flag;
    logic timer_external_flag;
    logic rx_baud_source_select;
    logic tx_baud_source_select;
    logic external_trigger_enable;
    logic timer_run;
    logic timer_counter_select;
    logic capture_reload_select;
  } timer_control_t;

  typedef struct packed {
    logic [5:0] reserved;
    logic clock_out_enable;
    logic down_count_enable;
  } timer_mode_t;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [2:0] MC_LAST = 3'h5;
  localparam logic [3:0] BAUD_DIV_LAST = 4'hF;

endpackage : timer2_pkg

// File: verification/timer_pins_model.sv
/*
 * Far-side model: timer pin with pull-up, trigger/direction pin, and the
 * other timer's overflow stream. Assumes the bench calls its tasks.
 */
`timescale 1ns/1ps

module timer_pins_model #(
  parameter int FIRST_PERIOD = 20
) (
  // clock
  input wire logic ref_clk,
  // timer pin, three-signal form
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_in,
  // trigger / direction pin
  output logic trig_pin,
  // serial port side
  output logic first_ovf
);
  logic ext_drive = 1'b1;
  logic trig_level = 1'b1;
  int div = 0;

  // pull-up holds the pin high when nobody drives it
  assign pin_in = pin_oe_n ? ext_drive : pin_out;
  assign trig_pin = trig_level;

  always @(posedge ref_clk) begin
    div <= (div == FIRST_PERIOD - 1) ? 0 : div + 1;
    first_ovf <= (div == FIRST_PERIOD - 1);
  end

  // two machine cycles per half period keeps every edge visible
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (12) @(posedge ref_clk);
      ext_drive <= 1'b0;
      repeat (12) @(posedge ref_clk);
      ext_drive <= 1'b1;
    end
  endtask : pulses

  task automatic set_trig(input logic v);
    @(posedge ref_clk);
    trig_level <= v;
  endtask : set_trig
endmodule : timer_pins_model

// File: verification/test_timer2_updown_clkout_baud.sv
/*
 * Self-checking bench for the up/down, clock-out and baud-rate timer.
 * Assumes the design package and the pins model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_timer2_updown_clkout_baud
  import timer2_pkg::*;
;
  localparam int FP = 20;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_in, pin_out, pin_oe_n, trig, first_ovf, tx_tick, rx_tick, irq;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] seed = 8'h21;

  timer2_updown_clkout_baud uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_clock_io_pin_in(pin_in), .timer_clock_io_pin_out(pin_out),
    .timer_clock_io_pin_oe_n(pin_oe_n), .timer_trigger_dir_pin(trig),
    .first_timer_ovf_tick(first_ovf), .tx_baud_tick(tx_tick), .rx_baud_tick(rx_tick),
    .timer_irq(irq));
  timer_pins_model #(.FIRST_PERIOD(FP)) pm (.ref_clk(ref_clk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_in(pin_in), .trig_pin(trig), .first_ovf(first_ovf));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ****
  // helpers
  // ****
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next

  function automatic logic ev(input int sel);
    return (sel == 0) ? pin_out : ((sel == 1) ? tx_tick : rx_tick);
  endfunction : ev

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // timer stopped before count and reload are touched
  task automatic setup(input logic [7:0] m, input logic [15:0] rl, input logic [15:0] cnt, input logic [7:0] c);
    wr(CTRL_ADDR, 8'h00);
    wr(RLD_LO_ADDR, rl[7:0]);
    wr(RLD_HI_ADDR, rl[15:8]);
    wr(CNT_LO_ADDR, cnt[7:0]);
    wr(CNT_HI_ADDR, cnt[15:8]);
    wr(MODE_ADDR, m);
    wr(CTRL_ADDR, c);
  endtask : setup

  // clocks between two rising edges of the chosen output
  task automatic gap(input int sel, output int n);
    logic p, c;
    int e;
    p = 1'b1;
    e = 0;
    n = 0;
    while (e < 2) begin
      @(posedge ref_clk);
      #1 c = ev(sel);
      if (e == 1) n++;
      if (c && !p) e++;
      p = c;
    end
  endtask : gap

  task automatic complete_run;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    logic [7:0] d, rh;
    logic [15:0] rl;
    int n, k;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(CTRL_ADDR, d); `CHK(d, CTRL_RESET)
    rd(MODE_ADDR, d); `CHK(d, MODE_RESET)
    rd(8'h5A, d); `CHK(d, 8'h00)
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      seed = lfsr_next(seed);
      rh = 8'h10 | (seed & 8'h0F);
      pm.set_trig(i == 0);
      setup(8'h01, {rh, 8'h34}, (i == 0) ? 16'hFFFE : {rh, 8'h36}, 8'h04);
      repeat (36) @(posedge ref_clk);
      rd(CTRL_ADDR, d); `CHK(d, 8'hC4)
      wr(CTRL_ADDR, 8'h00);
      rd(CNT_HI_ADDR, d); `CHK(d, (i == 0) ? rh : 8'hFF)
    end
    $display("up/down test done");
    seed = lfsr_next(seed);
    k = 3 + (seed & 8'h07);
    setup(8'h00, 16'h0000, 16'h0000, 8'h06);
    pm.pulses(k);
    repeat (12) @(posedge ref_clk);
    wr(CTRL_ADDR, 8'h00);
    rd(CNT_LO_ADDR, d); `CHK(d, k[7:0])
    `CHK(pin_oe_n, 1'b1)
    $display("counter test done");
    seed = lfsr_next(seed);
    rl = {8'hFF, 8'hF0 | (seed & 8'h0F)};
    setup(8'h02, rl, rl, 8'h04);
    gap(0, n); `CHK(n, 2 * (65536 - rl))
    `CHK(pin_oe_n, 1'b0)
    rd(CTRL_ADDR, d); `CHK(d, 8'h04)
    `CHK(irq, 1'b0)
    $display("clock-out test done");
    for (int i = 0; i < 2; i++) begin
      seed = lfsr_next(seed);
      rl = {8'hFF, 8'hF0 | (seed & 8'h0F)};
      setup(8'h00, rl, rl, (i == 1) ? 8'h24 : 8'h14);
      gap(1, n); `CHK(n, (i == 1) ? 16 * FP : 16 * (65536 - rl))
      gap(2, n); `CHK(n, (i == 1) ? 16 * (65536 - rl) : 16 * FP)
      rd(CTRL_ADDR, d); `CHK(d, (i == 1) ? 8'h24 : 8'h14)
    end
    setup(8'h00, rl, rl, 8'h1C);
    pm.set_trig(1'b1);
    repeat (18) @(posedge ref_clk);
    pm.set_trig(1'b0);
    rd(CTRL_ADDR, d); `CHK(d, 8'h1C)
    repeat (12) @(posedge ref_clk);
    rd(CTRL_ADDR, d); `CHK(d, 8'h5C)
    `CHK(irq, 1'b1)
    $display("baud test done");
    complete_run();
  end
endmodule : test_timer2_updown_clkout_baud
